// ---- pkg/dmct_pkg.sv ----
// Constants shared by both ends of the dual mode compare timer
package dmct_pkg;
  // Peripheral bus
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] A_MODE = 3'h0;
  localparam logic [ADDR_W-1:0] A_FLAGS = 3'h1;
  localparam logic [ADDR_W-1:0] A_CNT_HI = 3'h2;
  localparam logic [ADDR_W-1:0] A_CNT_LO = 3'h3;
  localparam logic [ADDR_W-1:0] A_CMP_HI = 3'h4;
  localparam logic [ADDR_W-1:0] A_CMP_LO = 3'h5;
  localparam logic [ADDR_W-1:0] A_STBY = 3'h6;
  // Field positions of timer_flags_and_control
  localparam int B_HI_OVF = 7;
  localparam int B_HI_MATCH = 6;
  localparam int B_HI_OVF_IE = 5;
  localparam int B_HI_CLR = 4;
  localparam int B_LO_OVF = 3;
  localparam int B_LO_MATCH = 2;
  localparam int B_LO_OVF_IE = 1;
  localparam int B_LO_CLR = 0;
  localparam logic [7:0] FLAG_MASK = 8'hcc;
  // Other fields
  localparam int B_SPLIT = 6;
  localparam int B_STBY = 2;
  // Reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] STBY_RST = 8'hff;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'hff;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  // Host APB map
  localparam int PADDR_W = 12;
  localparam logic [PADDR_W-1:0] P_CMD = 12'h000;
  localparam logic [PADDR_W-1:0] P_STAT = 12'h004;
  localparam int C_ADDR_LSB = 0;
  localparam int C_WR = 3;
  localparam int C_WDATA_LSB = 8;
  localparam int S_BUSY = 0;
  localparam int S_RDATA_LSB = 8;
endpackage : dmct_pkg

// ---- pkg/dmct_bus_if.sv ----
// Byte-wide peripheral bus between controller and timer
`timescale 1ns/1ps
`default_nettype none
interface dmct_bus_if;
  import dmct_pkg::*;
  logic sel;
  logic wr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata;
  logic [DATA_W-1:0] rdata;
  logic ack;
  modport dev (input sel, input wr, input addr, input wdata, output rdata, output ack);
  modport hst (output sel, output wr, output addr, output wdata, input rdata, input ack);
endinterface : dmct_bus_if
`default_nettype wire

// ---- logic/dmct_half.sv ----
// One 8-bit counter half with load, clear and compare
`timescale 1ns/1ps
`default_nettype none
module dmct_half
  import dmct_pkg::*;
#(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic clr,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  input wire logic [W-1:0] cmp,
  output logic [W-1:0] count_q,
  output logic at_max,
  output logic eq
);
  logic [W-1:0] count_d;
  logic [W-1:0] count_inc;

  assign count_inc = count_q + {{(W-1){1'b0}}, 1'b1};
  assign at_max = (count_q == BYTE_MAX);
  assign eq = (count_q == cmp);
  // A bus write wins over counting in the same cycle
  assign count_d = load ? load_val : clr ? BYTE_ZERO : tick ? count_inc : count_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= CNT_RST;
    end else begin
      count_q <= count_d;
    end
  end
endmodule : dmct_half
`default_nettype wire

// ---- logic/dmct_device.sv ----
// Timer end: counter halves, flags, control and byte bus with temporary latch
//
// Added by the designer: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dmct_device
  import dmct_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  dmct_bus_if.dev bus,
  input wire logic tick_lo,
  input wire logic tick_hi,
  input wire logic controller_timer_irq_enable_hi,
  input wire logic controller_timer_irq_enable_lo,
  output logic irq_hi_q,
  output logic irq_lo_q,
  output logic match_hi_q,
  output logic match_lo_q
);
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] armed_q;
  logic [7:0] armed_d;
  logic [7:0] mode_q;
  logic [7:0] module_clock_stop_one_q;
  logic [7:0] temp_q;
  logic [7:0] temp_d;
  logic [7:0] compare_upper_byte_q;
  logic [7:0] compare_lower_byte_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic ack_q;
  logic [7:0] counter_upper_byte;
  logic [7:0] counter_lower_byte;
  logic lo_max;
  logic hi_max;
  logic lo_eq;
  logic hi_eq;

  // Bus decode
  wire rd = bus.sel & ~bus.wr;
  wire wr = bus.sel & bus.wr;
  wire w_mode = wr & (bus.addr == A_MODE);
  wire w_flags = wr & (bus.addr == A_FLAGS);
  wire w_cnt_hi = wr & (bus.addr == A_CNT_HI);
  wire w_cnt_lo = wr & (bus.addr == A_CNT_LO);
  wire w_cmp_hi = wr & (bus.addr == A_CMP_HI);
  wire w_cmp_lo = wr & (bus.addr == A_CMP_LO);
  wire w_stby = wr & (bus.addr == A_STBY);
  wire r_flags = rd & (bus.addr == A_FLAGS);
  wire r_cnt_hi = rd & (bus.addr == A_CNT_HI);

  // Mode and standby
  wire split_mode_select = mode_q[B_SPLIT];
  wire timer_standby_ctrl = module_clock_stop_one_q[B_STBY];
  wire run = timer_standby_ctrl;
  wire wide = ~split_mode_select;

  // Counter loading through the temporary latch in wide mode
  wire ld_hi = split_mode_select ? w_cnt_hi : w_cnt_lo;
  wire ld_lo = w_cnt_lo;
  wire [7:0] hi_val = split_mode_select ? bus.wdata : temp_q;
  wire latch_wr = wide & (w_cnt_hi | w_cmp_hi);
  wire latch_rd = wide & r_cnt_hi;

  // Ticks: in wide mode the upper byte counts on lower overflow
  wire lo_tick = run & tick_lo;
  wire hi_tick = run & (split_mode_select ? tick_hi : (tick_lo & lo_max));

  // Match events fire on the tick that leaves the matching value
  wire match16 = lo_tick & lo_eq & hi_eq;
  wire hi_match_ev = split_mode_select ? (hi_tick & hi_eq) : match16;
  wire lo_match_ev = lo_tick & lo_eq;
  // A counter write in the same cycle swallows the overflow
  wire hi_ovf_ev = hi_tick & hi_max & ~ld_hi;
  wire lo_ovf_ev = lo_tick & lo_max & ~ld_lo;

  wire hi_clr = flags_q[B_HI_CLR] & hi_match_ev;
  wire lo_clr_split = flags_q[B_LO_CLR] & lo_match_ev;
  wire lo_clr = split_mode_select ? lo_clr_split : hi_clr;

  dmct_half #(
    .W(DATA_W)
  ) u_lo (
    .pclk(pclk),
    .presetn(presetn),
    .tick(lo_tick),
    .clr(lo_clr),
    .load(ld_lo),
    .load_val(bus.wdata),
    .cmp(compare_lower_byte_q),
    .count_q(counter_lower_byte),
    .at_max(lo_max),
    .eq(lo_eq)
  );

  dmct_half #(
    .W(DATA_W)
  ) u_hi (
    .pclk(pclk),
    .presetn(presetn),
    .tick(hi_tick),
    .clr(hi_clr),
    .load(ld_hi),
    .load_val(hi_val),
    .cmp(compare_upper_byte_q),
    .count_q(counter_upper_byte),
    .at_max(hi_max),
    .eq(hi_eq)
  );

  // Hardware set events placed at their flag positions
  wire [7:0] set_vec = {
    hi_ovf_ev,
    hi_match_ev,
    2'b00,
    lo_ovf_ev,
    lo_match_ev,
    2'b00
  };

  // Flag bits clear only on a zero written after reading them as one;
  // control bits are plain read/write
  genvar i;
  generate
    for (i = 0; i < DATA_W; i++) begin : g_flag
      if (FLAG_MASK[i]) begin : g_sticky
        wire clr_now = w_flags & ~bus.wdata[i] & armed_q[i];
        assign flags_d[i] = set_vec[i] | (flags_q[i] & ~clr_now);
        assign armed_d[i] = (r_flags & flags_q[i]) | (armed_q[i] & ~w_flags);
      end else begin : g_plain
        assign flags_d[i] = w_flags ? bus.wdata[i] : flags_q[i];
        assign armed_d[i] = 1'b0;
      end
    end
  endgenerate

  // Temporary latch: wide writes park the upper byte, wide upper counter byte reads park the lower
  assign temp_d = latch_wr ? bus.wdata : latch_rd ? counter_lower_byte : temp_q;

  // Read mux; the lower counter byte comes from the latch in wide mode
  wire [7:0] cnt_lo_rd = wide ? temp_q : counter_lower_byte;
  assign rdata_d = ~rd ? BYTE_ZERO :
                   (bus.addr == A_MODE) ? mode_q :
                   (bus.addr == A_FLAGS) ? flags_q :
                   (bus.addr == A_CNT_HI) ? counter_upper_byte :
                   (bus.addr == A_CNT_LO) ? cnt_lo_rd :
                   (bus.addr == A_CMP_HI) ? compare_upper_byte_q :
                   (bus.addr == A_CMP_LO) ? compare_lower_byte_q :
                   (bus.addr == A_STBY) ? module_clock_stop_one_q :
                   BYTE_ZERO;

  // Interrupt requests: overflow gated locally, all gated by the controller enable
  wire ovf_req_hi = flags_q[B_HI_OVF] & flags_q[B_HI_OVF_IE];
  wire ovf_req_lo = flags_q[B_LO_OVF] & flags_q[B_LO_OVF_IE];
  wire irq_hi_d = controller_timer_irq_enable_hi & (ovf_req_hi | flags_q[B_HI_MATCH]);
  wire irq_lo_d = controller_timer_irq_enable_lo & (ovf_req_lo | flags_q[B_LO_MATCH]);

  // Compare bytes; in wide mode the upper byte arrives from the latch
  wire cmp_hi_ld = split_mode_select ? w_cmp_hi : w_cmp_lo;
  wire [7:0] cmp_hi_val = split_mode_select ? bus.wdata : temp_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_upper_byte_q <= CMP_RST;
      compare_lower_byte_q <= CMP_RST;
      temp_q <= BYTE_ZERO;
    end else begin
      if (cmp_hi_ld) begin
        compare_upper_byte_q <= cmp_hi_val;
      end
      if (w_cmp_lo) begin
        compare_lower_byte_q <= bus.wdata;
      end
      temp_q <= temp_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= FLAGS_RST;
      armed_q <= FLAGS_RST;
      mode_q <= MODE_RST;
      module_clock_stop_one_q <= STBY_RST;
    end else begin
      flags_q <= flags_d;
      armed_q <= armed_d;
      if (w_mode) begin
        mode_q <= bus.wdata;
      end
      if (w_stby) begin
        module_clock_stop_one_q <= bus.wdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= BYTE_ZERO;
      ack_q <= 1'b0;
      irq_hi_q <= 1'b0;
      irq_lo_q <= 1'b0;
      match_hi_q <= 1'b0;
      match_lo_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      ack_q <= bus.sel;
      irq_hi_q <= irq_hi_d;
      irq_lo_q <= irq_lo_d;
      match_hi_q <= hi_match_ev;
      match_lo_q <= lo_match_ev;
    end
  end

  assign bus.rdata = rdata_q;
  assign bus.ack = ack_q;
endmodule : dmct_device
`default_nettype wire

// ---- logic/dmct_host.sv ----
// Controller end: APB slave that issues byte accesses on the peripheral bus
`timescale 1ns/1ps
`default_nettype none
module dmct_host
  import dmct_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  dmct_bus_if.hst bus
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_REQ = 3'b010,
    ST_WAIT = 3'b100
  } dmct_hst_t;

  dmct_hst_t state_q;
  dmct_hst_t state_d;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic [31:0] cmd_q;
  logic [7:0] last_rdata_q;
  logic sel_q;

  wire setup = psel & ~penable;
  wire hit_cmd = (paddr == P_CMD);
  wire hit_stat = (paddr == P_STAT);
  wire busy = (state_q != ST_IDLE);
  // Software keeps the upper-then-lower order itself; a command while busy is dropped
  wire cmd_go = psel & penable & pready_q & pwrite & hit_cmd & ~busy;
  wire [31:0] stat_word = {16'h0000, last_rdata_q, 7'h00, busy};
  wire [31:0] rd_mux = hit_cmd ? cmd_q : hit_stat ? stat_word : 32'h0000_0000;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: begin
        if (cmd_go) begin
          state_d = ST_REQ;
        end
      end
      ST_REQ: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        if (bus.ack) begin
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= ST_IDLE;
      cmd_q <= 32'h0000_0000;
      last_rdata_q <= BYTE_ZERO;
      sel_q <= 1'b0;
    end else begin
      state_q <= state_d;
      sel_q <= cmd_go;
      if (cmd_go) begin
        cmd_q <= pwdata;
      end
      if ((state_q == ST_WAIT) && bus.ack && !cmd_q[C_WR]) begin
        last_rdata_q <= bus.rdata;
      end
    end
  end

  // No wait state: answer is prepared during setup and stands in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= setup;
      prdata_q <= (setup & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_q <= setup & ~hit_cmd & ~hit_stat;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign bus.sel = sel_q;
  assign bus.wr = cmd_q[C_WR];
  assign bus.addr = cmd_q[C_ADDR_LSB +: ADDR_W];
  assign bus.wdata = cmd_q[C_WDATA_LSB +: DATA_W];
endmodule : dmct_host
`default_nettype wire

// ---- dv/dmct_props.sv ----
// Bus checker watching the byte bus between controller and timer
`timescale 1ns/1ps
`default_nettype none
module dmct_props
  import dmct_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic sel,
  input wire logic wr,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic ack
);
  logic [7:0] tmp_q, chi_q, clo_q, stby_q, mode_q;
  wire logic wr_hit = sel & wr;
  wire logic split = mode_q[B_SPLIT];
  // Shadow assumes wide compare writes always come as upper then lower pairs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmp_q <= BYTE_ZERO;
      chi_q <= CMP_RST;
      clo_q <= CMP_RST;
      stby_q <= STBY_RST;
      mode_q <= MODE_RST;
    end else if (wr_hit) begin
      if (!split && (addr == A_CMP_HI || addr == A_CNT_HI)) tmp_q <= wdata;
      if (addr == A_CMP_HI && split) chi_q <= wdata;
      if (addr == A_CMP_LO) clo_q <= wdata;
      if (addr == A_CMP_LO && !split) chi_q <= tmp_q;
      if (addr == A_STBY) stby_q <= wdata;
      if (addr == A_MODE) mode_q <= wdata;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ACK_ONE_AFTER_SEL: assert property (sel |=> ack)
    else $error("ack missing after request");
  AST_ACK_NEEDS_SEL: assert property (ack |-> $past(sel))
    else $error("ack without request");
  AST_RDATA_QUIET: assert property (!ack |-> rdata == BYTE_ZERO)
    else $error("rdata not zero outside ack");
  AST_CMP_HI_DIRECT: assert property (ack && $past(sel && !wr && addr == A_CMP_HI) |-> rdata == chi_q)
    else $error("compare upper read wrong");
  AST_CMP_LO_DIRECT: assert property (ack && $past(sel && !wr && addr == A_CMP_LO) |-> rdata == clo_q)
    else $error("compare lower read wrong");
  AST_STBY_READ: assert property (ack && $past(sel && !wr && addr == A_STBY) |-> rdata == stby_q)
    else $error("standby register read wrong");
  AST_MODE_READ: assert property (ack && $past(sel && !wr && addr == A_MODE) |-> rdata[B_SPLIT] == split)
    else $error("split select read wrong");
  AST_UNMAPPED_ZERO: assert property (ack && $past(sel && !wr && addr == 3'h7) |-> rdata == BYTE_ZERO)
    else $error("unmapped read not zero");
endmodule : dmct_props
`default_nettype wire

// ---- dv/dual_mode_compare_timer_status_bus_tb.sv ----
// Testbench joining controller and timer over the byte bus
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("unexpected %s exp %h seen %h", n, e, g); end end
module dual_mode_compare_timer_status_bus_tb;
  import dmct_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, tick_lo, tick_hi, en_hi, en_lo, pready, pslverr, irq_hi, irq_lo, last_err;
  logic match_hi, match_lo;
  logic [PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] v, c_hi, c_lo, e_mon;
  logic [2:0] ra [8] = '{A_MODE, A_FLAGS, A_CNT_HI, A_CNT_LO, A_CMP_HI, A_CMP_LO, A_STBY, 3'h7};
  logic [7:0] re [8] = '{MODE_RST, FLAGS_RST, CNT_RST, CNT_RST, CMP_RST, CMP_RST, STBY_RST, BYTE_ZERO};
  logic [7:0] expq [$];
  int fails, check_count, n_mhi, n_mlo;
  integer seed = 32'h92b4;
  dmct_bus_if bus ();
  dmct_device i_dmct_device (.pclk(pclk), .presetn(presetn), .bus(bus), .tick_lo(tick_lo), .tick_hi(tick_hi),
    .controller_timer_irq_enable_hi(en_hi), .controller_timer_irq_enable_lo(en_lo), .irq_hi_q(irq_hi),
    .irq_lo_q(irq_lo), .match_hi_q(match_hi), .match_lo_q(match_lo));
  dmct_host i_dmct_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus));
  dmct_props u_props (.pclk(pclk), .presetn(presetn), .sel(bus.sel), .wr(bus.wr), .addr(bus.addr),
    .wdata(bus.wdata), .rdata(bus.rdata), .ack(bus.ack));
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : final_report
  task automatic apb(input logic w, input logic [PADDR_W-1:0] a, input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic dev(input logic w, input logic [2:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [31:0] c;
    c = 32'h0;
    c[C_ADDR_LSB +: ADDR_W] = a;
    c[C_WR] = w;
    c[C_WDATA_LSB +: 8] = d;
    apb(1'b1, P_CMD, c, c);
    do apb(1'b0, P_STAT, 32'h0, c); while (c[S_BUSY] !== 1'b0);
    q = c[S_RDATA_LSB +: 8];
  endtask : dev
  task automatic wr8(input logic [2:0] a, input logic [7:0] d);
    dev(1'b1, a, d, v);
  endtask : wr8
  task automatic rd8(input logic [2:0] a, input logic [7:0] e);
    expq.push_back(e);
    dev(1'b0, a, 8'h00, v);
  endtask : rd8
  // Count pulses are one cycle wide and two cycles apart so each lands as a separate tick
  task automatic tk(input logic hi, input int n);
    repeat (n) begin
      if (hi) tick_hi <= 1'b1;
      else tick_lo <= 1'b1;
      @(posedge pclk);
      tick_hi <= 1'b0;
      tick_lo <= 1'b0;
      @(posedge pclk);
    end
  endtask : tk
  always @(posedge pclk) begin
    if (bus.ack === 1'b1 && bus.wr === 1'b0) begin
      e_mon = expq.pop_front();
      `CHK("rdata", e_mon, bus.rdata)
    end
  end
  // Match pulses last one cycle, so each edge that sees one counts one event
  always @(posedge pclk) begin
    if (match_hi === 1'b1) n_mhi++;
    if (match_lo === 1'b1) n_mlo++;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    final_report();
  end
  initial begin
    {psel, penable, pwrite, tick_lo, tick_hi, en_hi, en_lo} = 7'h00;
    paddr = '0;
    pwdata = '0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (ra[i]) rd8(ra[i], re[i]);
    apb(1'b0, 12'h008, 32'h0, r);
    `CHK("pslverr", 1'b1, last_err)
    wr8(A_FLAGS, FLAG_MASK);
    rd8(A_FLAGS, 8'h00);
    wr8(A_CMP_HI, 8'h00);
    wr8(A_CMP_LO, 8'h10);
    rd8(A_CMP_HI, 8'h00);
    wr8(A_CNT_HI, 8'h3c);
    wr8(A_CNT_LO, 8'hfe);
    tk(1'b0, 3);
    rd8(A_CNT_HI, 8'h3d);
    tk(1'b0, 2);
    rd8(A_CNT_LO, 8'h01);
    // A zero write only clears once a read has seen the flag set
    rd8(A_FLAGS, 8'h08);
    wr8(A_FLAGS, 8'h08);
    wr8(A_FLAGS, 8'h00);
    rd8(A_FLAGS, 8'h08);
    wr8(A_FLAGS, 8'h00);
    rd8(A_FLAGS, 8'h00);
    en_hi <= 1'b1;
    en_lo <= 1'b1;
    wr8(A_CNT_HI, 8'hff);
    wr8(A_CNT_LO, 8'hfe);
    wr8(A_FLAGS, 8'h20);
    tk(1'b0, 2);
    rd8(A_FLAGS, 8'ha8);
    `CHK("irq_hi", 1'b1, irq_hi)
    `CHK("irq_lo", 1'b0, irq_lo)
    wr8(A_FLAGS, 8'h00);
    rd8(A_FLAGS, 8'h00);
    `CHK("irq_hi", 1'b0, irq_hi)
    wr8(A_MODE, 8'h40);
    rd8(A_MODE, 8'h40);
    wr8(A_CMP_LO, 8'h05);
    wr8(A_CMP_HI, 8'h02);
    wr8(A_CNT_LO, 8'h03);
    wr8(A_CNT_HI, 8'h01);
    wr8(A_FLAGS, 8'h11);
    tk(1'b0, 3);
    tk(1'b1, 2);
    rd8(A_CNT_LO, 8'h00);
    rd8(A_CNT_HI, 8'h00);
    rd8(A_CMP_HI, 8'h02);
    rd8(A_FLAGS, 8'h55);
    `CHK("irq_hi", 1'b1, irq_hi)
    `CHK("irq_lo", 1'b1, irq_lo)
    `CHK("match_hi pulses", 32'd1, n_mhi)
    `CHK("match_lo pulses", 32'd1, n_mlo)
    wr8(A_STBY, 8'hfb);
    rd8(A_STBY, 8'hfb);
    tk(1'b0, 2);
    rd8(A_CNT_LO, 8'h00);
    wr8(A_STBY, STBY_RST);
    tk(1'b0, 1);
    rd8(A_CNT_LO, 8'h01);
    wr8(A_MODE, 8'h00);
    r = $random(seed);
    c_hi = r[7:0];
    c_lo = r[15:8];
    wr8(A_CMP_HI, c_hi);
    wr8(A_CMP_LO, c_lo);
    rd8(A_CMP_HI, c_hi);
    rd8(A_CMP_LO, c_lo);
    repeat (3) @(posedge pclk);
    `CHK("queue empty", 1'b1, (expq.size() == 0))
    final_report();
  end
endmodule : dual_mode_compare_timer_status_bus_tb
`default_nettype wire
